// *** inc/pcb_consts.svh ***
`ifndef PCB_CONSTS_SVH
`define PCB_CONSTS_SVH
// register base offsets (byte addresses)
`define PCB_OFS_ANALOG_SELECT 16'h6200
`define PCB_OFS_DIRECTION 16'h6210
`define PCB_OFS_PIN_LEVEL 16'h6220
`define PCB_OFS_OUTPUT_LATCH 16'h6230
`define PCB_OFS_OPEN_DRAIN 16'h6240
`define PCB_OFS_PULL_UP 16'h6250
`define PCB_OFS_PULL_DOWN 16'h6260
`define PCB_OFS_CN_CONTROL 16'h6270
`define PCB_OFS_CN_ENABLE 16'h6280
`define PCB_OFS_CN_STATUS 16'h6290
`define PCB_OFS_IRQ_STATUS 16'h62a0
`define PCB_OFS_IRQ_MASK 16'h62b0
// alias sub-offsets
`define PCB_SUB_BASE 2'h0
`define PCB_SUB_CLR 2'h1
`define PCB_SUB_SET 2'h2
`define PCB_SUB_INV 2'h3
// reset values
`define PCB_RST_ANALOG_SELECT 10'h00f
`define PCB_RST_DIRECTION 10'h3ff
`define PCB_RST_ZERO 10'h000
// control field positions
`define PCB_CN_ON_BIT 15
`define PCB_CN_IDLE_BIT 13
// bit availability
`define PCB_MASK_44PIN_ONLY 10'h1f4
`define PCB_ANSEL_USB_BIT 3
`define PCB_ANSEL_MASK 10'h00f
`endif

// *** inc/pcb_pkg.sv ***
package pcb_pkg;
    // alias operation applied by a write
    typedef enum logic [1:0] {
        PCB_OP_WRITE = 2'b00,
        PCB_OP_CLEAR = 2'b01,
        PCB_OP_SET = 2'b10,
        PCB_OP_TOGGLE = 2'b11
    } pcb_op_e;
    // decoded bus write toward one register
    typedef struct packed {
        logic hit;
        pcb_op_e op;
        logic [9:0] data;
    } pcb_wr_s;
endpackage

// *** rtl/pcb_alias_reg.sv ***
`timescale 1ns/1ps
`default_nettype none
// one base register with clear/set/toggle alias write
module pcb_alias_reg
    import pcb_pkg::*;
#(
    parameter int W = 10,
    parameter logic [W-1:0] RST = '0,
    parameter logic [W-1:0] IMPL = '1
) (
    input wire logic core_clk, // system clock
    input wire logic rst, // sync reset, high
    input wire pcb_wr_s wr, // decoded write
    output logic [W-1:0] q // register value
);
    logic [W-1:0] next_q; // value after this cycle's write

    // only bits written as one change under an alias; zeros keep old value
    always_comb
    begin
        unique case (wr.op)
            PCB_OP_WRITE: next_q = wr.data[W-1:0];
            PCB_OP_CLEAR: next_q = q & ~wr.data[W-1:0];
            PCB_OP_SET: next_q = q | wr.data[W-1:0];
            PCB_OP_TOGGLE: next_q = q ^ wr.data[W-1:0];
        endcase
    end

    // single-cycle update, no read-modify-write window
    always_ff @(posedge core_clk)
    begin
        if (rst)
            q <= RST & IMPL;
        else if (wr.hit)
            q <= next_q & IMPL;
    end
endmodule
`default_nettype wire

// *** rtl/pcb_change_detect.sv ***
`timescale 1ns/1ps
`default_nettype none
// per-pin change notification status
module pcb_change_detect #(
    parameter int W = 10
) (
    input wire logic core_clk, // system clock
    input wire logic rst, // sync reset, high
    input wire logic enable, // module on
    input wire logic [W-1:0] pins, // pin levels
    input wire logic [W-1:0] watch, // per-pin enable
    input wire logic pin_read, // pin register read
    output logic [W-1:0] status // changed since last read
);
    logic [W-1:0] prev; // last sampled level

    // remember the previous level to spot edges; it follows the pins
    // through reset too, so the idle level never looks like a fresh edge
    always_ff @(posedge core_clk)
    begin
        prev <= pins;
    end

    // a change in the read cycle wins over the clear
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge core_clk)
            begin
                if (rst)
                    status[i] <= 1'b0;
                else if (enable && watch[i] && (pins[i] != prev[i]))
                    status[i] <= 1'b1;
                else if (pin_read)
                    status[i] <= 1'b0;
            end
        end
    endgenerate
endmodule
`default_nettype wire

// *** rtl/pcb_port_bank.sv ***
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "pcb_consts.svh"
// Summary of operation
// - each register has clear, set, toggle aliases; here the interrupt and change status flags have none
// - alias acts only on bits written one
// - bits written zero keep their value
// - alias reads return no defined value; here they read zero
// - aliases at base plus 4, 8, 12
// - unimplemented bits and upper half read zero
// - whole bank absent in 28-pin build
// - bits 2, 4-8 only in 44-pin build
// - analog bit 3 needs usb and 36/44 pins
// - direction one means input; reset inputs
// - pin read gives pins, write hits latch
// - analog pins read zero as pin level
// - status flags change since last pin read
module pcb_port_bank
    import pcb_pkg::*;
#(
    parameter int PINS = 28, // package pin count: 28, 36 or 44
    parameter bit HAS_USB = 1'b0, // usb-capable build
    parameter int W = 10 // port width
) (
    input wire logic core_clk, // system clock
    input wire logic rst, // sync reset, high
    input wire logic [15:0] addr, // byte address
    input wire logic [31:0] wdata, // write data
    input wire logic wr_en, // write strobe
    input wire logic rd_en, // read strobe
    output logic [31:0] rdata, // read data, cycle after strobe
    input wire logic [W-1:0] pin_in, // pin input levels
    output logic [W-1:0] pin_out, // pin output values
    output logic [W-1:0] pin_oe, // pin output enables
    output logic [W-1:0] pull_up, // weak pull-up enables
    output logic [W-1:0] pull_down, // weak pull-down enables
    output logic [W-1:0] analog_en, // analog mode per pin
    output logic irq // level interrupt
);
    // the smallest build has no port c at all; every access then reads zero
    localparam bit PRESENT = (PINS != 28);
    // implemented bit masks for this build
    // missing bits are masked at the flops, so no alias can ever set them
    localparam logic [W-1:0] IMPL = !PRESENT ? '0 :
        (PINS == 44) ? '1 : ~(W'(`PCB_MASK_44PIN_ONLY));
    // analog bit 3 also needs the usb build; bit 2 follows the 44-pin mask
    localparam logic [W-1:0] ANS_IMPL = IMPL & W'(`PCB_ANSEL_MASK) &
        ~((HAS_USB && PINS >= 36) ? '0 : (W'(1) << `PCB_ANSEL_USB_BIT));
    // control bits sit in the low two slots of a W-wide register
    localparam logic [W-1:0] CTRL_IMPL = {W{PRESENT}}; // control bits held in W-wide slice

    // decode fields
    logic [11:0] reg_sel; // base address with sub-offset dropped
    logic [1:0] sub; // alias selector
    logic pin_read; // read of pin-level base
    // register contents
    logic [W-1:0] analog_select; // analog selection
    logic [W-1:0] direction; // one = input
    logic [W-1:0] output_latch; // output latch
    logic [W-1:0] open_drain_select; // open-drain mode
    logic [W-1:0] pull_up_enable; // pull-up enables
    logic [W-1:0] pull_down_enable; // pull-down enables
    logic [W-1:0] change_notify_enable; // change watch enables
    logic [W-1:0] change_notify_status; // change flags
    logic [W-1:0] cn_ctrl_lo; // control bits, stored packed
    // interrupt state
    logic [W-1:0] irq_mask; // interrupt mask
    logic [W-1:0] irq_status; // sticky interrupt flags
    logic [W-1:0] pin_level; // pin read value
    // read path
    logic [31:0] next_rdata; // read mux output
    logic cn_on; // change module on
    pcb_wr_s wr_ans; // write toward analog select
    pcb_wr_s wr_dir; // write toward direction
    pcb_wr_s wr_lat; // write toward latch, from either address
    pcb_wr_s wr_odc; // write toward open-drain select
    pcb_wr_s wr_pu; // write toward pull-up enables
    pcb_wr_s wr_pd; // write toward pull-down enables
    pcb_wr_s wr_cnc; // write toward change control
    pcb_wr_s wr_cne; // write toward change enables
    pcb_wr_s wr_msk; // write toward interrupt mask
    logic irq_clr; // write-one-clear of the interrupt flags

    // each register owns a 16-byte slot: base, clear, set and toggle words
    assign reg_sel = addr[15:4];
    assign sub = addr[3:2];
    // the interrupt flags have no aliases, so only the exact address clears
    assign irq_clr = wr_en && PRESENT && (addr == `PCB_OFS_IRQ_STATUS);
    assign pin_read = rd_en && PRESENT && ({reg_sel, 4'h0} == `PCB_OFS_PIN_LEVEL)
        && (sub == `PCB_SUB_BASE);

    // build the decoded write toward one base address
    function automatic pcb_wr_s dec(input logic [15:0] base);
        pcb_wr_s w;
        // the slot address selects the register, the sub-offset the operation
        w.hit = wr_en && PRESENT && ({reg_sel, 4'h0} == base);
        w.op = pcb_op_e'(sub);
        // only the low W bits are stored; the upper half is dropped
        w.data = wdata[W-1:0];
        return w;
    endfunction

    // control register packs ON at slot 1, idle-halt at slot 0
    function automatic pcb_wr_s dec_ctrl();
        pcb_wr_s w;
        w = dec(`PCB_OFS_CN_CONTROL);
        w.data = '0;
        w.data[1] = wdata[`PCB_CN_ON_BIT];
        w.data[0] = wdata[`PCB_CN_IDLE_BIT];
        return w;
    endfunction

    // writes to pin-level address go to the latch
    always_comb
    begin
        // every decode sees the same address, so at most one hit is high
        wr_ans = dec(`PCB_OFS_ANALOG_SELECT);
        wr_dir = dec(`PCB_OFS_DIRECTION);
        // latch: its own address first, then the pin-level address
        wr_lat = dec(`PCB_OFS_OUTPUT_LATCH);
        if (!wr_lat.hit)
            wr_lat = dec(`PCB_OFS_PIN_LEVEL);
        wr_odc = dec(`PCB_OFS_OPEN_DRAIN);
        wr_pu = dec(`PCB_OFS_PULL_UP);
        wr_pd = dec(`PCB_OFS_PULL_DOWN);
        wr_cnc = dec_ctrl();
        wr_cne = dec(`PCB_OFS_CN_ENABLE);
        wr_msk = dec(`PCB_OFS_IRQ_MASK);
    end

    // analog select: reset marks the shared pins analog
    pcb_alias_reg #(.W(W), .RST(W'(`PCB_RST_ANALOG_SELECT)), .IMPL(ANS_IMPL)) u_ans (
        .core_clk(core_clk),
        .rst(rst),
        .wr(wr_ans),
        .q(analog_select)
    );

    // reset leaves every pin an input
    pcb_alias_reg #(.W(W), .RST(W'(`PCB_RST_DIRECTION)), .IMPL(IMPL)) u_dir (
        .core_clk(core_clk),
        .rst(rst),
        .wr(wr_dir),
        .q(direction)
    );

    // latch is unknown after reset; zero is a safe pick
    // since every pin starts as an input, no pin is driven before software acts
    pcb_alias_reg #(.W(W), .RST(W'(`PCB_RST_ZERO)), .IMPL(IMPL)) u_lat (
        .core_clk(core_clk),
        .rst(rst),
        .wr(wr_lat),
        .q(output_latch)
    );

    // open-drain select: a set bit releases the pin while the latch is one
    pcb_alias_reg #(.W(W), .RST(W'(`PCB_RST_ZERO)), .IMPL(IMPL)) u_odc (
        .core_clk(core_clk),
        .rst(rst),
        .wr(wr_odc),
        .q(open_drain_select)
    );

    // weak pull-up enables
    pcb_alias_reg #(.W(W), .RST(W'(`PCB_RST_ZERO)), .IMPL(IMPL)) u_pu (
        .core_clk(core_clk),
        .rst(rst),
        .wr(wr_pu),
        .q(pull_up_enable)
    );

    // weak pull-down enables; nothing stops both pulls being on at once,
    // software has to keep them off on driven outputs
    pcb_alias_reg #(.W(W), .RST(W'(`PCB_RST_ZERO)), .IMPL(IMPL)) u_pd (
        .core_clk(core_clk),
        .rst(rst),
        .wr(wr_pd),
        .q(pull_down_enable)
    );

    // change control: only the on and idle-halt bits are kept, packed low
    // so the same alias register serves; the read mux spreads them out again
    pcb_alias_reg #(.W(W), .RST(W'(`PCB_RST_ZERO)), .IMPL(CTRL_IMPL)) u_cnc (
        .core_clk(core_clk),
        .rst(rst),
        .wr(wr_cnc),
        .q(cn_ctrl_lo)
    );

    // per-pin change watch enables
    pcb_alias_reg #(.W(W), .RST(W'(`PCB_RST_ZERO)), .IMPL(IMPL)) u_cne (
        .core_clk(core_clk),
        .rst(rst),
        .wr(wr_cne),
        .q(change_notify_enable)
    );

    // interrupt mask, same layout as the sticky flags
    // aliases let software mask one pin without touching the others
    pcb_alias_reg #(.W(W), .RST(W'(`PCB_RST_ZERO)), .IMPL(IMPL)) u_msk (
        .core_clk(core_clk),
        .rst(rst),
        .wr(wr_msk),
        .q(irq_mask)
    );

    // slot 1 of the packed control word is the module-on bit
    assign cn_on = cn_ctrl_lo[1];

    // change flags track pin edges between pin reads
    // a pin-level read clears them, so each edge is reported once
    pcb_change_detect #(.W(W)) u_cn (
        .core_clk(core_clk),
        .rst(rst),
        .enable(cn_on),
        .pins(pin_in & IMPL),
        .watch(change_notify_enable),
        .pin_read(pin_read),
        .status(change_notify_status)
    );

    // analog pins read low; missing bits read zero
    // an output pin reads back the level that it drives
    assign pin_level = pin_in & IMPL & ~analog_select;

    // sticky interrupt flags: set while a change flag stands, write-one clears
    always_ff @(posedge core_clk)
    begin
        if (rst)
            irq_status <= '0;
        else if (irq_clr)
            // a flag set again in the clear cycle stays set
            irq_status <= (irq_status & ~wdata[W-1:0]) | change_notify_status; // set wins
        else
            // a flag follows the change status and holds until cleared
            irq_status <= irq_status | change_notify_status;
    end

    // level output while any unmasked flag stands
    assign irq = |(irq_status & irq_mask);

    // read mux; alias reads and unmapped addresses return zero
    // zero is the cheapest defined answer; software reads the base to see a result
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (PRESENT && sub == `PCB_SUB_BASE)
        begin
            unique case ({reg_sel, 4'h0})
                `PCB_OFS_ANALOG_SELECT: next_rdata[W-1:0] = analog_select;
                `PCB_OFS_DIRECTION: next_rdata[W-1:0] = direction;
                `PCB_OFS_PIN_LEVEL: next_rdata[W-1:0] = pin_level;
                `PCB_OFS_OUTPUT_LATCH: next_rdata[W-1:0] = output_latch;
                `PCB_OFS_OPEN_DRAIN: next_rdata[W-1:0] = open_drain_select;
                `PCB_OFS_PULL_UP: next_rdata[W-1:0] = pull_up_enable;
                `PCB_OFS_PULL_DOWN: next_rdata[W-1:0] = pull_down_enable;
                `PCB_OFS_CN_CONTROL:
                begin
                    // only the on and idle-halt bits are stored
                    next_rdata[`PCB_CN_ON_BIT] = cn_ctrl_lo[1];
                    next_rdata[`PCB_CN_IDLE_BIT] = cn_ctrl_lo[0];
                end
                `PCB_OFS_CN_ENABLE: next_rdata[W-1:0] = change_notify_enable;
                `PCB_OFS_CN_STATUS: next_rdata[W-1:0] = change_notify_status;
                `PCB_OFS_IRQ_STATUS: next_rdata[W-1:0] = irq_status;
                `PCB_OFS_IRQ_MASK: next_rdata[W-1:0] = irq_mask;
                default: next_rdata = 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    // read data registered, valid only the cycle after the strobe
    // zero between reads, so a stale word never looks like an answer
    always_ff @(posedge core_clk)
    begin
        if (rst)
            rdata <= 32'h0000_0000;
        else if (rd_en)
            rdata <= next_rdata;
        else
            rdata <= 32'h0000_0000;
    end

    // pin drive per bit: an open-drain bit only ever pulls low, and an
    // outside pull-up must give the high level
    genvar b;
    generate
        for (b = 0; b < W; b++)
        begin : g_pin
            // output value: open-drain bits never present a one
            assign pin_out[b] = output_latch[b] & ~open_drain_select[b];
            // drive when an implemented output, released for an open-drain bit whose latch is one
            assign pin_oe[b] = ~direction[b] & IMPL[b] &
                ~(open_drain_select[b] & output_latch[b]);
        end
    endgenerate

    // pull and analog controls go straight out
    assign pull_up = pull_up_enable;
    assign pull_down = pull_down_enable;
    assign analog_en = analog_select;
endmodule
`default_nettype wire

// *** dv/pcb_port_bank_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// bus-side and pin-side relations of the port bank
module pcb_port_bank_chk #(
    parameter int W = 10
) (
    input wire logic core_clk, // clock
    input wire logic rst, // reset
    input wire logic [15:0] addr, // address
    input wire logic [31:0] wdata, // write data
    input wire logic wr_en, // write
    input wire logic rd_en, // read
    input wire logic [31:0] rdata, // read data
    input wire logic [W-1:0] pin_oe, // drives
    input wire logic [W-1:0] pull_up, // pull-ups
    input wire logic [W-1:0] pull_down, // pull-downs
    input wire logic [W-1:0] analog_en, // analog
    input wire logic irq // interrupt
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_idle; !rd_en |=> rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data without read");
    property p_upper; rd_en |=> rdata[31:16] == 16'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper half not zero");
    property p_alias; rd_en && addr[3:2] != 2'h0 |=> rdata == 32'h0; endproperty
    a_alias: assert property (p_alias) else $error("alias read not zero");
    property p_rst; $fell(rst) |-> pin_oe == '0 && !irq; endproperty
    a_rst: assert property (p_rst) else $error("pins not inputs after reset");
    property p_set;
        wr_en && addr == 16'h6258 |=> pull_up == ($past(pull_up) | $past(wdata[W-1:0]));
    endproperty
    a_set: assert property (p_set) else $error("set alias wrong");
    property p_clr;
        wr_en && addr == 16'h6264 |=> pull_down == ($past(pull_down) & ~$past(wdata[W-1:0]));
    endproperty
    a_clr: assert property (p_clr) else $error("clear alias wrong");
    property p_inv;
        wr_en && addr == 16'h620c |=> analog_en[3:0] == ($past(analog_en[3:0]) ^ $past(wdata[3:0]));
    endproperty
    a_inv: assert property (p_inv) else $error("toggle alias wrong");
    property p_keep; wr_en && addr[15:4] != 12'h625 |=> $stable(pull_up); endproperty
    a_keep: assert property (p_keep) else $error("pull-up hit by other address");
    property p_ana; rd_en && addr == 16'h6220 |=> (rdata[W-1:0] & $past(analog_en)) == '0; endproperty
    a_ana: assert property (p_ana) else $error("analog pin read high");
    cover property (wr_en && addr == 16'h6258);
    cover property (rd_en && addr == 16'h6220);
    cover property (irq);
endmodule
bind pcb_port_bank pcb_port_bank_chk #(.W(W)) u_chk (.core_clk(core_clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pin_oe(pin_oe),
    .pull_up(pull_up), .pull_down(pull_down), .analog_en(analog_en), .irq(irq));
`default_nettype wire

// *** dv/pcb_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// outside world of the pins: a source, weak pulls, floating lines
module pcb_pin_model #(
    parameter int W = 10
) (
    input wire logic core_clk, // clock
    input wire logic [W-1:0] pin_out, // bank value
    input wire logic [W-1:0] pin_oe, // bank drives
    input wire logic [W-1:0] pull_up, // weak high
    input wire logic [W-1:0] pull_down, // weak low
    input wire logic [W-1:0] ext_val, // source level
    input wire logic [W-1:0] ext_en, // source active
    output logic [W-1:0] level // pin level
);
    logic flip = 1'b0; // floating value
    // a floating line wanders so a stale level never passes as held
    always @(posedge core_clk)
        flip <= ~flip;
    // bank drive wins, then the source, then pulls, then float
    always_comb
        for (int i = 0; i < W; i++)
            level[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                pull_up[i] | (~pull_down[i] & flip);
endmodule
`default_nettype wire

// *** dv/pcb_port_bank_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the port register bank
module pcb_port_bank_tb;
    logic core_clk = 1'b0; // clock
    logic rst = 1'b1; // reset
    logic [15:0] addr = 16'h0; // address
    logic [31:0] wdata = 32'h0; // write data
    logic wr_en = 1'b0; // write strobe
    logic rd_en = 1'b0; // read strobe
    logic rd_q = 1'b0; // read taken last cycle
    logic [31:0] rdata; // read data
    logic [9:0] pin_in, pin_out, pin_oe, pull_up, pull_down, analog_en; // pin side
    logic [9:0] ext_val = 10'h2a5; // outside level
    logic [9:0] ext_en = 10'h3ff; // outside source on
    logic irq; // interrupt
    logic [31:0] exq[$]; // expected reads
    logic [9:0] m[12]; // register model
    logic [31:0] d; // random data
    int rl[8] = '{0, 1, 3, 4, 5, 6, 8, 11}; // writable registers
    integer seed = 95186; // seed
    integer error_cnt = 0; // mismatches
    integer compares = 0; // comparisons
    integer i, k; // indices
    always #20 core_clk = ~core_clk;
    pcb_port_bank #(.PINS(44), .HAS_USB(1'b1), .W(10)) dut (.core_clk(core_clk), .rst(rst),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pull_up(pull_up), .pull_down(pull_down),
        .analog_en(analog_en), .irq(irq));
    pcb_pin_model u_pins (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_up(pull_up), .pull_down(pull_down), .ext_val(ext_val), .ext_en(ext_en),
        .level(pin_in));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // one bus cycle; a read leaves its expectation for the monitor
    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] v,
        input logic [31:0] e);
        @(posedge core_clk);
        wr_en <= w;
        rd_en <= ~w;
        addr <= a;
        wdata <= v;
        if (!w)
            exq.push_back(e);
        @(posedge core_clk);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask
    task automatic end_of_test;
        // a read whose answer never came is a failure too
        if (exq.size() != 0)
        begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t: %0d reads never answered", $time, exq.size());
        end
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // read data stands one cycle after the strobe was taken
    always @(posedge core_clk)
    begin
        rd_q <= rd_en;
        if (rd_q)
            chk(rdata, exq.pop_front());
    end
    // watchdog: the run needs well under a thousand cycles
    initial
    begin
        repeat (3000) @(posedge core_clk);
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: watchdog", $time);
        end_of_test();
    end
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        for (i = 0; i < 12; i++)
            m[i] = 10'h0;
        m[0] = 10'h00f;
        m[1] = 10'h3ff;
        for (i = 0; i < 12; i++)
            acc(1'b0, 16'h6200 + 16'(i * 16), 32'h0, {22'h0, (i == 2) ? 10'h2a0 : m[i]});
        acc(1'b0, 16'h62c0, 32'h0, 32'h0);
        $display("test reset values done");
        // every alias kind on each writable register except change control, random data
        for (k = 0; k < 8; k++)
            for (i = 0; i < 4; i++)
            begin
                d = $random(seed);
                case (i)
                    0: m[rl[k]] = d[9:0];
                    1: m[rl[k]] = m[rl[k]] & ~d[9:0];
                    2: m[rl[k]] = m[rl[k]] | d[9:0];
                    default: m[rl[k]] = m[rl[k]] ^ d[9:0];
                endcase
                if (rl[k] == 0)
                    m[0] = m[0] & 10'h00f;
                acc(1'b1, 16'h6200 + 16'(rl[k] * 16 + i * 4), d, 32'h0);
                acc(1'b0, 16'h6200 + 16'(rl[k] * 16), 32'h0, {22'h0, m[rl[k]]});
                if (i != 0)
                    acc(1'b0, 16'h6200 + 16'(rl[k] * 16 + i * 4), 32'h0, 32'h0);
            end
        $display("test alias operations done");
        // latch out through the pins, then analog pins read low
        d = $random(seed);
        acc(1'b1, 16'h6200, 32'h0, 32'h0);
        acc(1'b1, 16'h6240, 32'h0, 32'h0);
        acc(1'b1, 16'h6214, 32'h3ff, 32'h0);
        acc(1'b1, 16'h6220, d, 32'h0);
        repeat (4) @(posedge core_clk);
        chk({22'h0, pin_oe}, 32'h3ff);
        chk({22'h0, pin_out}, {22'h0, d[9:0]});
        acc(1'b0, 16'h6230, 32'h0, {22'h0, d[9:0]});
        acc(1'b0, 16'h6220, 32'h0, {22'h0, d[9:0]});
        acc(1'b1, 16'h6208, 32'hf, 32'h0);
        acc(1'b0, 16'h6220, 32'h0, {22'h0, d[9:4], 4'h0});
        $display("test pin path done");
        // change notification with masked, unmasked and cleared interrupt
        acc(1'b1, 16'h6200, 32'h0, 32'h0);
        acc(1'b1, 16'h6210, 32'h3ff, 32'h0);
        acc(1'b1, 16'h6270, 32'h8000, 32'h0);
        acc(1'b1, 16'h6280, 32'h3ff, 32'h0);
        acc(1'b1, 16'h62b0, 32'h0, 32'h0);
        repeat (4) @(posedge core_clk);
        acc(1'b0, 16'h6220, 32'h0, 32'h2a5);
        acc(1'b1, 16'h62a0, 32'h3ff, 32'h0);
        d = $random(seed) | 32'h1;
        ext_val <= ext_val ^ d[9:0];
        repeat (4) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        acc(1'b0, 16'h6290, 32'h0, {22'h0, d[9:0]});
        acc(1'b1, 16'h62b0, 32'h3ff, 32'h0);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h1);
        acc(1'b0, 16'h6220, 32'h0, {22'h0, ext_val});
        acc(1'b0, 16'h6290, 32'h0, 32'h0);
        acc(1'b1, 16'h62a0, 32'h3ff, 32'h0);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        $display("test change notify done");
        repeat (3) @(posedge core_clk);
        end_of_test();
    end
endmodule
`default_nettype wire
